/* File: rtl/intc_defs.svh */
/*
  constants of the interrupt priority and sense block: register byte offsets,
  field positions, reset values and source counts.
  assumes it is included once per file by its bare name.
*/
// Functional notes
// - eight 16-bit read/write priority registers, four 4-bit level fields each
// - field code 0 is lowest level, code F highest, numeric order between
// - register a holds pins 0..3 levels, top field to bottom field
// - register b holds pins 4..7 levels, top field to bottom field
// - register c holds transfer channels 0..3 levels, top to bottom
// - register d: timer 0 compare, timer 0 overflow, then two timer 1 fields
// - register e: upper fields timer 2, lower fields timer 3
// - register f: timer 4 upper fields, serial 0 then serial 1 below
// - register g: converter, transfer controller, compare timers 0 and 1
// - register h: watchdog and bus compare top, port enable next, rest reserved
// - sources sharing one field all use its single programmed level
// - priority registers clear to zero on either reset, hold otherwise
// - sense control register is 16 bits, cleared only by power-on reset
// - sense bit 15 reads the synchronised nonmaskable pin level, not writable
// - sense bits 14..9 read zero; software writes zero there
// - sense bit 8 picks nonmaskable edge: 0 falling, 1 rising
// - sense bits 7..0 pick pins 0..7 mode: 0 low level, 1 falling edge
// - serial 1 sources use vectors 132..135, four-byte slots, receive error first
// - vectors 136, 140, 144, 148, 152 over 153, then 156 lowest
// - two converter units share a field, vector 136 over 137
// - forward a request only when its level exceeds the cpu mask
// - equal levels resolve by default order, then rank inside the field
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

`define OFS_PRIO_A 8'h00
`define OFS_PRIO_LAST 8'h1C
`define OFS_SENSE 8'h20
`define OFS_PEND 8'h24
`define PRIO_RESET 16'h0000
`define SENSE_RESET 9'h000
`define SENSE_NMI_LEVEL_BIT 15
`define SENSE_NMI_EDGE_BIT 8
`define NUM_PRIO_REGS 8
`define NUM_EXT_PINS 8
`define NUM_SOURCES 51
`define NUM_PERIPH 43
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

/* File: rtl/intc_pkg.sv */
/*
  types and the fixed source table of the interrupt priority and sense block.
  assumes sources are listed from highest to lowest default priority.
*/
package intc_pkg;
  typedef logic [3:0] prio_level_t;
  typedef logic [7:0] vector_num_t;
  typedef logic [4:0] field_idx_t;
  typedef logic [5:0] source_idx_t;

  // vector number per source, highest default priority first
  parameter vector_num_t src_vector [51] = '{
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
    8'h48, 8'h4C, 8'h50, 8'h54,
    8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h60, 8'h61, 8'h64, 8'h65,
    8'h68, 8'h69, 8'h6C, 8'h6D, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74,
    8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C,
    8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
    8'h88, 8'h89, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h99, 8'h9C
  };

  // field per source: register times four plus slot, 0 on top
  parameter field_idx_t src_field [51] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0A, 5'h0B,
    5'h0C, 5'h0C, 5'h0C, 5'h0C, 5'h0D, 5'h0E, 5'h0E, 5'h0F, 5'h0F,
    5'h10, 5'h10, 5'h11, 5'h11, 5'h12, 5'h12, 5'h12, 5'h12, 5'h13,
    5'h14, 5'h14, 5'h14, 5'h14, 5'h15,
    5'h16, 5'h16, 5'h16, 5'h16, 5'h17, 5'h17, 5'h17, 5'h17,
    5'h18, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1C, 5'h1D
  };
endpackage : intc_pkg

/* File: rtl/pin_sense.sv */
/*
  synchroniser and edge finder for asynchronous request pins.
  assumes pins idle high and may change at any time relative to clk.
*/
`timescale 1ns/1ps
module pin_sense
#(
  parameter int WIDTH = 9
)
(
  input wire logic clk,                  // system clock
  input wire logic sys_rst,              // synchronous reset
  input wire logic ce,                   // clock enable
  input wire logic [WIDTH-1:0] pin_async, // raw pins
  output logic [WIDTH-1:0] pin_level,    // synchronised level
  output logic [WIDTH-1:0] pin_fall,     // one-cycle falling edge
  output logic [WIDTH-1:0] pin_rise      // one-cycle rising edge
);
  // ----------------------------------------------------------------
  // per-pin two-flop synchroniser plus history flop
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      logic meta_reg;
      logic sync_reg;
      logic hist_reg;
      // first flop only feeds the second
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
          hist_reg <= 1'b1;
        end
        else if (ce)
        begin
          meta_reg <= pin_async[i];
          sync_reg <= meta_reg;
          hist_reg <= sync_reg;
        end
      end
      // edges seen only on synchronised samples
      assign pin_level[i] = sync_reg;
      assign pin_fall[i] = hist_reg & ~sync_reg & ce;
      assign pin_rise[i] = ~hist_reg & sync_reg & ce;
    end
  endgenerate
endmodule : pin_sense

/* File: rtl/interrupt_priority_and_sense.sv */
/*
  interrupt priority and sense controller: priority registers, sense control,
  pin detection, arbitration and request to the cpu, with an axi4-lite slave.
  assumes peripheral requests are same-clock levels held until serviced, and
  that the cpu pulses cpu_ack when it takes the presented request.
*/
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "intc_defs.svh"
module interrupt_priority_and_sense
(
  input wire logic clk,                         // system clock, 25 MHz
  input wire logic sys_rst,                     // power-on reset, synchronous
  input wire logic manual_rst,                  // manual reset, synchronous
  input wire logic ce,                          // clock enable
  input wire logic [7:0] s_axi_awaddr,          // write address
  input wire logic s_axi_awvalid,               // write address valid
  output logic s_axi_awready,                   // write address ready
  input wire logic [31:0] s_axi_wdata,          // write data
  input wire logic [3:0] s_axi_wstrb,           // write byte strobes
  input wire logic s_axi_wvalid,                // write data valid
  output logic s_axi_wready,                    // write data ready
  output logic [1:0] s_axi_bresp,               // write response
  output logic s_axi_bvalid,                    // write response valid
  input wire logic s_axi_bready,                // write response ready
  input wire logic [7:0] s_axi_araddr,          // read address
  input wire logic s_axi_arvalid,               // read address valid
  output logic s_axi_arready,                   // read address ready
  output logic [31:0] s_axi_rdata,              // read data
  output logic [1:0] s_axi_rresp,               // read response
  output logic s_axi_rvalid,                    // read data valid
  input wire logic s_axi_rready,                // read data ready
  input wire logic [7:0] ext_req_n,             // external request pins, low active
  input wire logic nmi_pin,                     // nonmaskable input pin
  input wire logic [42:0] periph_req,           // on-chip source requests
  input wire logic [3:0] cpu_interrupt_mask,    // cpu mask level
  input wire logic cpu_ack,                     // cpu takes presented request
  input wire logic nmi_ack,                     // cpu takes nonmaskable request
  output logic cpu_irq_req,                     // maskable request to cpu
  output intc_pkg::prio_level_t cpu_irq_level,  // level of presented request
  output intc_pkg::vector_num_t cpu_irq_vector, // vector of presented request
  output logic [11:0] cpu_vector_offset,        // table byte offset of vector
  output logic nmi_req                          // nonmaskable request pending
);
  import intc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] prio_reg [`NUM_PRIO_REGS];
  logic nmi_edge_sel_reg;
  logic [7:0] ext_sense_sel_reg;
  logic [7:0] ext_edge_flag_reg;
  logic nmi_pend_reg;
  source_idx_t sel_idx_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [8:0] pin_level;
  logic [8:0] pin_fall;
  logic [8:0] pin_rise;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  pin_sense #(.WIDTH(9)) u_pin_sense
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin_async({nmi_pin, ext_req_n}),
    .pin_level(pin_level),
    .pin_fall(pin_fall),
    .pin_rise(pin_rise)
  );

  // ----------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------
  logic aw_fire;
  logic w_fire;
  logic write_go;
  logic wr_mapped;
  logic [15:0] wr_lane_mask;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  // both halves held and no response outstanding
  assign write_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_mapped = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= `OFS_PEND);
  assign wr_lane_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // address and data captured in either order
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end
    else if (ce)
    begin
      if (aw_fire)
      begin
        s_axi_awready <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (write_go)
      begin
        s_axi_awready <= 1'b1;
      end
      if (w_fire)
      begin
        s_axi_wready <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (write_go)
      begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response, error for unmapped or misaligned address
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end
    else if (ce)
    begin
      if (write_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // priority registers
  // ----------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < `NUM_PRIO_REGS; r++)
    begin : g_prio
      // cleared by either reset, kept otherwise (standby included)
      always_ff @(posedge clk)
      begin
        if (sys_rst || manual_rst)
        begin
          prio_reg[r] <= `PRIO_RESET;
        end
        else if (ce && write_go && aw_addr_reg == 8'(4 * r))
        begin
          prio_reg[r] <= (prio_reg[r] & ~wr_lane_mask) | (w_data_reg[15:0] & wr_lane_mask);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sense control register
  // ----------------------------------------------------------------
  // only power-on reset clears it; bits 15..9 have no storage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {nmi_edge_sel_reg, ext_sense_sel_reg} <= `SENSE_RESET;
    end
    else if (ce && write_go && aw_addr_reg == `OFS_SENSE)
    begin
      if (w_strb_reg[1])
      begin
        nmi_edge_sel_reg <= w_data_reg[`SENSE_NMI_EDGE_BIT];
      end
      if (w_strb_reg[0])
      begin
        ext_sense_sel_reg <= w_data_reg[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------
  logic ar_fire;
  logic [31:0] rd_word;
  logic rd_mapped;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rd_mapped = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `OFS_PEND);

  // read mux, narrow registers in the low bits
  always_comb
  begin
    rd_word = 32'h00000000;
    if (s_axi_araddr <= `OFS_PRIO_LAST)
    begin
      rd_word[15:0] = prio_reg[s_axi_araddr[4:2]];
    end
    else if (s_axi_araddr == `OFS_SENSE)
    begin
      rd_word[`SENSE_NMI_LEVEL_BIT] = pin_level[8];
      rd_word[`SENSE_NMI_EDGE_BIT] = nmi_edge_sel_reg;
      rd_word[7:0] = ext_sense_sel_reg; // bits 14..9 stay zero
    end
    else if (s_axi_araddr == `OFS_PEND)
    begin
      rd_word[8] = nmi_pend_reg;
      rd_word[7:0] = ext_edge_flag_reg;
    end
  end

  // one read at a time, data held until taken
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_OKAY;
    end
    else if (ce)
    begin
      if (ar_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mapped ? rd_word : 32'h00000000;
        s_axi_rresp <= rd_mapped ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // external pin and nonmaskable detection
  // ----------------------------------------------------------------
  logic [7:0] ext_pending;
  genvar p;
  generate
    for (p = 0; p < `NUM_EXT_PINS; p++)
    begin : g_ext
      logic take_clear;
      // pin p uses sense bit 7-p
      assign take_clear = cpu_ack && cpu_irq_req && sel_idx_reg == 6'(p);
      assign ext_pending[p] = ext_sense_sel_reg[7 - p] ? ext_edge_flag_reg[p] : ~pin_level[p];
      // held edge flag, a new edge beats the acknowledge clear
      always_ff @(posedge clk)
      begin
        if (sys_rst || manual_rst)
        begin
          ext_edge_flag_reg[p] <= 1'b0;
        end
        else if (ce)
        begin
          if (ext_sense_sel_reg[7 - p] && pin_fall[p])
          begin
            ext_edge_flag_reg[p] <= 1'b1;
          end
          else if (take_clear || !ext_sense_sel_reg[7 - p])
          begin
            ext_edge_flag_reg[p] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // nonmaskable edge on the selected polarity, set wins over acknowledge
  always_ff @(posedge clk)
  begin
    if (sys_rst || manual_rst)
    begin
      nmi_pend_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (nmi_edge_sel_reg ? pin_rise[8] : pin_fall[8])
      begin
        nmi_pend_reg <= 1'b1;
      end
      else if (nmi_ack)
      begin
        nmi_pend_reg <= 1'b0;
      end
    end
  end
  assign nmi_req = nmi_pend_reg;

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [`NUM_SOURCES-1:0] src_pend;
  prio_level_t best_lvl;
  source_idx_t best_idx;
  logic best_found;
  assign src_pend = {periph_req, ext_pending};

  // level of one field: register from the upper index bits, slot 0 on top
  function automatic prio_level_t field_level(input field_idx_t f);
    logic [15:0] word;
    word = prio_reg[f[4:2]];
    case (f[1:0])
      2'h0: field_level = word[15:12];
      2'h1: field_level = word[11:8];
      2'h2: field_level = word[7:4];
      default: field_level = word[3:0];
    endcase
  endfunction : field_level

  // strictly higher level wins; on a tie the earlier table entry stays
  always_comb
  begin
    prio_level_t lvl;
    lvl = 4'h0;
    best_lvl = 4'h0;
    best_idx = 6'h00;
    best_found = 1'b0;
    for (int i = 0; i < `NUM_SOURCES; i++)
    begin
      lvl = field_level(src_field[i]); // shared fields give one level
      if (src_pend[i] && (!best_found || lvl > best_lvl))
      begin
        best_lvl = lvl;
        best_idx = 6'(i);
        best_found = 1'b1;
      end
    end
  end

  // presented request, registered each cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst || manual_rst)
    begin
      cpu_irq_req <= 1'b0;
      cpu_irq_level <= 4'h0;
      cpu_irq_vector <= 8'h00;
      cpu_vector_offset <= 12'h000;
      sel_idx_reg <= 6'h00;
    end
    else if (ce)
    begin
      cpu_irq_req <= best_found && (best_lvl > cpu_interrupt_mask);
      cpu_irq_level <= best_lvl;
      cpu_irq_vector <= src_vector[best_idx];
      cpu_vector_offset <= {2'b00, src_vector[best_idx], 2'b00};
      sel_idx_reg <= best_idx;
    end
  end
endmodule : interrupt_priority_and_sense

/* File: sim/interrupt_priority_and_sense_monitor.sv */
/*
  port checks of the interrupt priority and sense block.
  assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module interrupt_priority_and_sense_monitor
(
  input wire logic clk, // clock
  input wire logic sys_rst, // power-on reset
  input wire logic manual_rst, // manual reset
  input wire logic ce, // clock enable
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [3:0] cpu_interrupt_mask, // cpu mask
  input wire logic nmi_ack, // nmi taken
  input wire logic cpu_ack, // request taken
  input wire logic cpu_irq_req, // request out
  input wire intc_pkg::prio_level_t cpu_irq_level, // level out
  input wire intc_pkg::vector_num_t cpu_irq_vector, // vector out
  input wire logic [11:0] cpu_vector_offset, // table offset
  input wire logic nmi_req // nmi pending
);
  import intc_pkg::*;
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // request path
  // ----------------------------------------
  AST_OFFSET: assert property (cpu_vector_offset == {2'b00, cpu_irq_vector, 2'b00})
    else $error("offset not four times vector");
  AST_MASK: assert property (cpu_irq_req && $past(ce) |-> cpu_irq_level > $past(cpu_interrupt_mask))
    else $error("request not above mask");
  AST_LEVEL0: assert property (cpu_irq_req |-> cpu_irq_level != 4'h0)
    else $error("level zero forwarded");
  AST_MRST: assert property (manual_rst |=> !cpu_irq_req && !nmi_req)
    else $error("request survives manual reset");
  AST_NMI_HOLD: assert property (ce && nmi_req && !nmi_ack && !manual_rst |=> nmi_req)
    else $error("nmi dropped unacked");
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  AST_WLAT: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("late write response");
  AST_BDONE: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  AST_RLAT: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  AST_RDONE: assert property (ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after handshake");
  cover property ($rose(cpu_irq_req));
  cover property ($rose(nmi_req));
  cover property (cpu_ack && cpu_irq_req);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : interrupt_priority_and_sense_monitor

bind interrupt_priority_and_sense interrupt_priority_and_sense_monitor mon_u (.clk, .sys_rst, .manual_rst, .ce,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .cpu_interrupt_mask, .nmi_ack, .cpu_ack,
  .cpu_irq_req, .cpu_irq_level, .cpu_irq_vector, .cpu_vector_offset, .nmi_req);

/* File: sim/cpu_core_model.sv */
/*
  cpu core model: takes requests after a delay.
  assumes the bench enables taking and sets the delay.
*/
`timescale 1ns/1ps
module cpu_core_model
(
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic ack_en, // taking allowed
  input wire logic [3:0] ack_delay, // cycles before taking
  input wire logic cpu_irq_req, // forwarded request
  input wire logic nmi_req, // nmi pending
  output logic cpu_ack, // request taken
  output logic nmi_ack // nmi taken
);
  logic [3:0] wait_reg;
  // take a request after ack_delay cycles
  always_ff @(posedge clk)
  begin
    wait_reg <= (ack_en && cpu_irq_req && !sys_rst) ? wait_reg + 4'h1 : 4'h0;
    cpu_ack <= !sys_rst && ack_en && cpu_irq_req && wait_reg == ack_delay;
    nmi_ack <= !sys_rst && ack_en && nmi_req && !nmi_ack;
  end
endmodule : cpu_core_model

/* File: sim/tb_interrupt_priority_and_sense.sv */
/*
  self-checking bench of the interrupt priority and sense block.
  assumes design, package, cpu model and monitor are compiled before it.
*/
`timescale 1ns/1ps
module tb_interrupt_priority_and_sense;
  import intc_pkg::*;
  logic clk, sys_rst, manual_rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nmi_pin, cpu_ack, nmi_ack;
  logic cpu_irq_req, nmi_req, ack_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ext_req_n;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, cpu_interrupt_mask, ack_delay;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [42:0] periph_req;
  logic [11:0] cpu_vector_offset;
  logic [15:0] lfsr_reg, rnd;
  prio_level_t cpu_irq_level;
  vector_num_t cpu_irq_vector;
  int err_total, check_count, prio[8], sense, k, j;
  localparam int vec_tab[12] = '{132, 133, 134, 135, 136, 137, 140, 144, 148, 152, 153, 156};
  localparam int fld_tab[12] = '{23, 23, 23, 23, 24, 24, 25, 26, 27, 28, 28, 29};

  interrupt_priority_and_sense dut_u (.clk, .sys_rst, .manual_rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_req_n, .nmi_pin, .periph_req, .cpu_interrupt_mask, .cpu_ack, .nmi_ack, .cpu_irq_req,
    .cpu_irq_level, .cpu_irq_vector, .cpu_vector_offset, .nmi_req);
  cpu_core_model cpu_u (.clk, .sys_rst, .ack_en, .ack_delay, .cpu_irq_req, .nmi_req, .cpu_ack, .nmi_ack);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic conclude();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] lfsr();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg;
  endfunction : lfsr

  function automatic logic bad(input logic [7:0] a);
    return a > 8'h24 || a[1:0] != 2'b00;
  endfunction : bad

  function automatic logic [31:0] rexp(input int i);
    return i < 8 ? 32'(prio[i]) : {16'h0, nmi_pin, 6'h00, 9'(sense)};
  endfunction : rexp

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // bus write, model tracks mapped places
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aw, w;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1;
    w = 1;
    n = 0;
    while ((aw || w || !s_axi_bvalid) && n < 60)
    begin
      @(posedge clk);
      n++;
      if (aw && s_axi_awready)
      begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready)
      begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, {bad(a), 1'b0});
    if (n >= 60) err_total++;
    if (!bad(a) && a < 8'h20) prio[a[4:2]] = int'(d[15:0]);
    if (a == 8'h20) sense = int'(d[8:0]);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] exp);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 60);
    s_axi_rready <= 1'b0;
    chk("rtime", n < 60, 1);
    chk("rdata", s_axi_rdata, exp);
    chk("rresp", s_axi_rresp, {bad(a), 1'b0});
  endtask : axr

  task automatic rd_all();
    for (int i = 0; i < 9; i++)
      axr(8'(i * 4), rexp(i));
  endtask : rd_all

  // reference arbitration, later sources
  task automatic irq_cmp();
    int bl, bv, f, lv;
    bl = 0;
    bv = 0;
    for (int i = 0; i < 12; i++)
    begin
      f = fld_tab[i];
      lv = (prio[f / 4] >> (12 - 4 * (f % 4))) & 15;
      if (periph_req[31 + i] && lv > bl)
      begin
        bl = lv;
        bv = vec_tab[i];
      end
    end
    chk("irq_req", cpu_irq_req, bl > cpu_interrupt_mask);
    if (bl > 0) chk("irq_sel", {cpu_irq_level, cpu_irq_vector, cpu_vector_offset}, {4'(bl), 8'(bv), 12'(bv * 4)});
  endtask : irq_cmp

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #400000;
    err_total++;
    conclude();
  end

  initial
  begin
    lfsr_reg = 16'h6E00;
    sys_rst = 1'b1;
    ce = 1'b1;
    nmi_pin = 1'b1;
    ext_req_n = 8'hFF;
    s_axi_wstrb = 4'hF;
    ack_delay = 4'h2;
    {periph_req, cpu_interrupt_mask, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, manual_rst, ack_en} = '0;
    prio = '{default: 0};
    sense = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd_all();
    for (j = 0; j < 9; j++)
      axw(8'(j * 4), j < 8 ? 32'(lfsr()) : 32'(lfsr() & 16'h01FF | 16'h8000));
    rd_all();
    axw(8'h28, 32'h0000FFFF);
    axr(8'h28, 32'h0);
    axr(8'h02, 32'h0);
    for (k = 0; k < 40; k++)
    begin
      for (j = 5; j < 8; j++)
        axw(8'(j * 4), 32'(lfsr()));
      rnd = lfsr();
      @(posedge clk);
      periph_req <= 43'(rnd[11:0]) << 31;
      cpu_interrupt_mask <= rnd[15:12];
      step(2);
      irq_cmp();
    end
    @(posedge clk);
    manual_rst <= 1'b1;
    periph_req <= '0;
    cpu_interrupt_mask <= 4'h0;
    repeat (2) @(posedge clk);
    manual_rst <= 1'b0;
    prio = '{default: 0};
    rd_all();
    for (j = 0; j < 8; j++)
    begin
      ack_delay <= (j < 4) ? 4'h2 : 4'h6;
      axw(8'(j / 4 * 4), 32'(j + 8) << (12 - 4 * (j % 4)));
      axw(8'h20, 32'(j % 2) << (7 - j));
      @(posedge clk);
      ext_req_n[j] <= 1'b0;
      step(5);
      chk("pin_sel", {cpu_irq_req, cpu_irq_level, cpu_irq_vector}, {1'b1, 4'(j + 8), 8'(64 + j)});
      @(posedge clk);
      ext_req_n[j] <= 1'b1;
      step(5);
      chk("pin_hold", cpu_irq_req, j % 2);
      axr(8'h24, 32'(j % 2) << j);
      @(posedge clk);
      ack_en <= 1'b1;
      step(12);
      chk("pin_clear", cpu_irq_req, 0);
      @(posedge clk);
      ack_en <= 1'b0;
    end
    for (j = 0; j < 4; j++)
    begin
      if (j % 2 == 0) axw(8'h20, 32'(j / 2) << 8);
      @(posedge clk);
      nmi_pin <= ~nmi_pin;
      step(5);
      chk("nmi_req", nmi_req, nmi_pin == j / 2);
      axr(8'h20, rexp(8));
      @(posedge clk);
      ack_en <= 1'b1;
      step(6);
      chk("nmi_clear", nmi_req, 0);
      @(posedge clk);
      ack_en <= 1'b0;
    end
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    sense = 0;
    prio = '{default: 0};
    rd_all();
    conclude();
  end
endmodule : tb_interrupt_priority_and_sense
